// ### rtl/serial_host_register_port.sv
module serial_host_register_port #(
  parameter int ADDR_W = serial_port_pkg::ADDR_W,
  parameter int WORD_W = serial_port_pkg::WORD_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic reg_wr,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [WORD_W-1:0] reg_wdata,
  input wire logic [WORD_W-1:0] reg_rdata
);

  // ---------------- system clock side state ----------------
  logic [WORD_W-1:0] ctrl_reg;
  logic [WORD_W-1:0] rd_hold_reg;
  logic rd_pend_reg;
  logic reg_wr_reg;
  logic reg_rd_reg;
  logic [ADDR_W-1:0] reg_addr_reg;
  logic [WORD_W-1:0] reg_wdata_reg;

  // ---------------- link side state (sclk) ----------------
  serial_port_pkg::phase_e phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] cmd1_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic words_done_reg;

  logic wr_tgl_reg;
  logic [ADDR_W-1:0] wr_addr_hold_reg;
  logic [WORD_W-1:0] wr_data_hold_reg;
  logic rd_tgl_reg;
  logic [ADDR_W-1:0] rd_addr_hold_reg;

  // falling-edge launch state
  logic rd_on_reg;
  logic rd_first_reg;
  logic [WORD_W-1:0] rd_shift_reg;

  // ---------------- decode ----------------
  wire [WORD_W-1:0] shift_next = {shift_reg[WORD_W-2:0], serial_in};
  wire word_end = (bit_cnt_reg == 4'hF);
  wire cmd_read = cmd1_reg[serial_port_pkg::CMD_READ_BIT];
  wire cmd_bcast = cmd1_reg[serial_port_pkg::CMD_BCAST_BIT];
  wire cmd_address_auto_increment = cmd1_reg[serial_port_pkg::CMD_ADDRESS_AUTO_INCREMENT_BIT];
  wire [serial_port_pkg::UNIT_W-1:0] cmd_unit =
    cmd1_reg[serial_port_pkg::CMD_UNIT_LSB +: serial_port_pkg::UNIT_W];
  wire [serial_port_pkg::UNIT_W-1:0] device_unit_id =
    ctrl_reg[serial_port_pkg::CTRL_UNIT_LSB +: serial_port_pkg::UNIT_W];
  // unit id is quasi-static: the host gap after a control write covers it
  wire unit_match = (cmd_unit == device_unit_id);
  wire loop_through_disable = ctrl_reg[serial_port_pkg::CTRL_LOOP_DIS_BIT];
  wire shared_output_enable = ctrl_reg[serial_port_pkg::CTRL_SHARED_BIT];

  // extended-address bit is trusted set; the address is always 23 bits
  wire [ADDR_W-1:0] cmd_addr = {
    cmd1_reg[serial_port_pkg::CMD_HI_ADDR_LSB +: serial_port_pkg::HI_ADDR_W],
    shift_next};
  wire [ADDR_W-1:0] addr_inc = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};

  wire in_data = (phase_reg == serial_port_pkg::PH_DATA);
  // later words of a single access are dropped, not rewritten
  wire wr_fire = in_data && word_end && !cmd_read &&
                 (cmd_address_auto_increment || !words_done_reg) &&
                 (cmd_bcast || unit_match);
  wire rd_ok = cmd_read && unit_match;
  // first fetch at end of second command; prefetch after each word's
  // first bit, once the current word has been copied to the shifter
  wire rd_first_fire = rd_ok && word_end &&
                       (phase_reg == serial_port_pkg::PH_CMD2);
  wire rd_next_fire = rd_ok && in_data && cmd_address_auto_increment &&
                      (bit_cnt_reg == 4'h1);
  wire next_is_bit0 = in_data && (bit_cnt_reg == 4'h0);
  wire just_bit0 = in_data && (bit_cnt_reg == 4'h1);

  // ---------------- link: rising edge decode ----------------
  // chip select high clears the frame so a new low starts clean
  // device reset clears it too: the pin may never have risen yet
  always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
    if (cs_n || rst) begin
      phase_reg <= serial_port_pkg::PH_CMD1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= '0;
      cmd1_reg <= '0;
      addr_reg <= '0;
      words_done_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      case (phase_reg)
        serial_port_pkg::PH_CMD1: begin
          if (word_end) begin
            cmd1_reg <= shift_next;
            phase_reg <= serial_port_pkg::PH_CMD2;
          end
        end
        serial_port_pkg::PH_CMD2: begin
          if (word_end) begin
            addr_reg <= cmd_addr;
            phase_reg <= serial_port_pkg::PH_DATA;
          end
        end
        serial_port_pkg::PH_DATA: begin
          if (word_end) begin
            words_done_reg <= 1'b1;
            if (cmd_address_auto_increment) begin
              addr_reg <= addr_inc;
            end
          end
        end
        default: begin
          phase_reg <= serial_port_pkg::PH_CMD1;
        end
      endcase
    end
  end

  // toggles survive deselect so the far side never sees a false event
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wr_tgl_reg <= 1'b0;
      wr_addr_hold_reg <= '0;
      wr_data_hold_reg <= '0;
      rd_tgl_reg <= 1'b0;
      rd_addr_hold_reg <= '0;
    end else begin
      if (wr_fire) begin
        wr_tgl_reg <= ~wr_tgl_reg;
        wr_addr_hold_reg <= addr_reg;
        wr_data_hold_reg <= shift_next;
      end
      if (rd_first_fire) begin
        rd_tgl_reg <= ~rd_tgl_reg;
        rd_addr_hold_reg <= cmd_addr;
      end else if (rd_next_fire) begin
        rd_tgl_reg <= ~rd_tgl_reg;
        rd_addr_hold_reg <= addr_inc;
      end
    end
  end

  // ---------------- link: falling edge launch ----------------
  always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
    if (cs_n || rst) begin
      rd_on_reg <= 1'b0;
      rd_first_reg <= 1'b0;
      rd_shift_reg <= '0;
    end else if (next_is_bit0) begin
      // one word only unless auto-increment
      rd_on_reg <= rd_ok && (cmd_address_auto_increment || !words_done_reg);
      rd_first_reg <= 1'b1;
    end else if (just_bit0) begin
      rd_first_reg <= 1'b0;
      rd_shift_reg <= {rd_hold_reg[WORD_W-2:0], 1'b0};
    end else begin
      rd_shift_reg <= {rd_shift_reg[WORD_W-2:0], 1'b0};
    end
  end

  // bit 15 of each word comes straight from the fetched word, since
  // the launching fall may precede the fetch; it is stable by bit 0 sample
  wire read_bit = rd_first_reg ? rd_hold_reg[WORD_W-1] :
                  rd_shift_reg[WORD_W-1];
  wire pass_bit = loop_through_disable ? 1'b1 : serial_in;

  // loop-through must be combinational, so these two are not registered
  assign serial_out = rd_on_reg ? read_bit : pass_bit;
  assign serial_out_oe = shared_output_enable ? ~cs_n : 1'b1;

  // ---------------- crossings ----------------
  logic wr_pulse;
  logic rd_pulse;

  toggle_sync u_wr_sync (
    .clk(clk_sys),
    .rst(rst),
    .tgl_in(wr_tgl_reg),
    .pulse(wr_pulse)
  );

  toggle_sync u_rd_sync (
    .clk(clk_sys),
    .rst(rst),
    .tgl_in(rd_tgl_reg),
    .pulse(rd_pulse)
  );

  // write holds stay put for a whole word time, read address holds for at least two sclk periods; both exceed the sync delay
  wire wr_is_ctrl = (wr_addr_hold_reg == serial_port_pkg::CTRL_ADDR);
  wire rd_is_ctrl = (rd_addr_hold_reg == serial_port_pkg::CTRL_ADDR);

  // ---------------- system side registers ----------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= serial_port_pkg::CTRL_RESET;
      rd_hold_reg <= '0;
      rd_pend_reg <= 1'b0;
      reg_wr_reg <= 1'b0;
      reg_rd_reg <= 1'b0;
      reg_addr_reg <= '0;
      reg_wdata_reg <= '0;
    end else begin
      reg_wr_reg <= wr_pulse && !wr_is_ctrl;
      reg_rd_reg <= rd_pulse && !rd_is_ctrl;
      rd_pend_reg <= reg_rd_reg;
      if (wr_pulse) begin
        if (wr_is_ctrl) begin
          ctrl_reg <= wr_data_hold_reg & serial_port_pkg::CTRL_MASK;
        end else begin
          reg_addr_reg <= wr_addr_hold_reg;
          reg_wdata_reg <= wr_data_hold_reg;
        end
      end else if (rd_pulse && !rd_is_ctrl) begin
        reg_addr_reg <= rd_addr_hold_reg;
      end
      if (rd_pulse && rd_is_ctrl) begin
        rd_hold_reg <= ctrl_reg;
      end else if (rd_pend_reg) begin
        rd_hold_reg <= reg_rdata;
      end
    end
  end

  assign reg_wr = reg_wr_reg;
  assign reg_rd = reg_rd_reg;
  assign reg_addr = reg_addr_reg;
  assign reg_wdata = reg_wdata_reg;
endmodule

// ### rtl/serial_port_pkg.sv
package serial_port_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 23;
  localparam int UNIT_W = 5;
  localparam int HI_ADDR_W = 7;

  // first command word fields
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_BCAST_BIT = 14;
  localparam int CMD_EXT_BIT = 13;
  localparam int CMD_ADDRESS_AUTO_INCREMENT_BIT = 12;
  localparam int CMD_UNIT_LSB = 7;
  localparam int CMD_HI_ADDR_LSB = 0;

  // serial_port_control register
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 23'h000000;
  localparam int CTRL_UNIT_LSB = 0;
  localparam int CTRL_LOOP_DIS_BIT = 8;
  localparam int CTRL_SHARED_BIT = 9;
  localparam logic [WORD_W-1:0] CTRL_MASK = 16'h031F;
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;

  // host-side timing: gaps in shift clocks, rate in MHz, turnaround in ns
  localparam int SCLK_MAX_MHZ = 27;
  localparam int ACCESS_GAP_SCLK = 3;
  localparam int CONFIG_WRITE_GAP_SCLK = 4;
  localparam int READ_TURNAROUND_SCLK = 4;
  localparam int READ_TURNAROUND_NS = 138;
  localparam int CLK_SYS_PERIOD_NS = 8;
  // fetch must finish inside this many system clocks
  localparam int READ_TURNAROUND_CYC =
    READ_TURNAROUND_NS / CLK_SYS_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_CMD1 = 2'b00,
    PH_CMD2 = 2'b01,
    PH_DATA = 2'b10
  } phase_e;
endpackage

// ### rtl/toggle_sync.sv
module toggle_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic tgl_in,
  output logic pulse
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // only s2 reads s1
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= tgl_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign pulse = s2_reg ^ s3_reg;
endmodule

// ### sim/serial_host_model.sv
module serial_host_model (
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HP = 20; // 40 ns period, below 27 MHz
  logic [15:0] dq [4];
  logic [15:0] rq [4];
  logic [15:0] m1;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    // known data words keep the idle line free of unknowns
    for (int i = 0; i < 4; i++) dq[i] = 16'h0000;
  end
  // msb first, bit set after falling edge
  task automatic shift(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #(HP);
      r[i] = serial_out;
      sclk = 1'b1;
      #(HP);
      sclk = 1'b0;
    end
  endtask
  task automatic access(input logic [15:0] c1, input logic [15:0] c2,
                        input int nw);
    logic [15:0] m2;
    cs_n = 1'b0;
    #(HP);
    shift(c1, m1);
    shift(c2, m2);
    if (c1[15]) #(8 * HP); // clock stands for fetch
    for (int i = 0; i < nw; i++) shift(dq[i], rq[i]);
    #(HP);
    cs_n = 1'b1;
    serial_in = ~serial_in; // idle line must not look held
    #(8 * HP);
  endtask
endmodule

// ### sim/serial_host_register_port_test.sv
module serial_host_register_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic sclk, cs_n, serial_in, serial_out, serial_out_oe, reg_wr, reg_rd;
  logic [22:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] mem [16];
  int num_errors = 0;
  int n_compared = 0;
  localparam logic [15:0] AW [3] = '{16'h1111, 16'hA5C3, 16'h8001};
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
  always #4 clk_sys = ~clk_sys;
  assign reg_rdata = mem[reg_addr[3:0]];
  always @(posedge clk_sys) if (reg_wr) mem[reg_addr[3:0]] <= reg_wdata;
  serial_host_register_port u_dut (.clk_sys(clk_sys), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  serial_host_model u_host (.sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out));
  task test_done;
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t_reset;
    u_host.access(16'hA000, 16'h0000, 1);
    `CHK(u_host.rq[0], 16'h0000)
    `CHK(u_host.m1, 16'hA000)
  endtask
  task t_single;
    u_host.dq[0] = 16'h1234;
    u_host.dq[1] = 16'h5678;
    u_host.access(16'h2001, 16'h0005, 2);
    `CHK(reg_addr, 23'h010005)
    `CHK(mem[6], 16'h0000)
    `CHK(mem[5], 16'h1234)
    u_host.dq[0] = 16'h0000;
    u_host.access(16'hA001, 16'h0005, 1);
    `CHK(u_host.rq[0], 16'h1234)
  endtask
  task t_auto;
    for (int i = 0; i < 3; i++) u_host.dq[i] = AW[i];
    u_host.access(16'h3000, 16'h0008, 3); // not the control word
    for (int i = 0; i < 3; i++) `CHK(mem[8 + i], AW[i])
    for (int i = 0; i < 3; i++) u_host.dq[i] = 16'h0000;
    u_host.access(16'hB000, 16'h0008, 3);
    for (int i = 0; i < 3; i++) `CHK(u_host.rq[i], AW[i])
  endtask
  task t_unit;
    u_host.dq[0] = 16'h0003;
    u_host.access(16'h2000, 16'h0000, 1);
    u_host.dq[0] = 16'hBEEF;
    u_host.access(16'h2000, 16'h0002, 1);
    `CHK(mem[2], 16'h0000)
    u_host.access(16'h6000, 16'h0002, 1);
    `CHK(mem[2], 16'hBEEF)
    u_host.dq[0] = 16'h0F0F;
    u_host.access(16'hA000, 16'h0002, 1);
    `CHK(u_host.rq[0], 16'h0F0F)
    u_host.dq[0] = 16'h0000;
    u_host.access(16'hA180, 16'h0002, 1);
    `CHK(u_host.rq[0], 16'hBEEF)
    u_host.dq[0] = 16'h0103;
    u_host.access(16'h2180, 16'h0000, 1);
    u_host.dq[0] = 16'h0000;
    u_host.access(16'hA180, 16'h0000, 1);
    `CHK(u_host.m1, 16'hFFFF)
    `CHK(u_host.rq[0], 16'h0103)
    u_host.dq[0] = 16'h0203;
    u_host.access(16'h2180, 16'h0000, 1);
    `CHK(serial_out_oe, 1'b0)
    u_host.dq[0] = 16'h0000;
    u_host.access(16'h2180, 16'h0000, 1);
    `CHK(u_host.m1, 16'h2180)
  endtask
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    // a real rising edge, so the async-cleared link flops see reset
    #1 rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_single;
    t_auto;
    t_unit;
    test_done;
  end
  // whole run needs roughly 34 us
  initial begin
    #100000;
    num_errors++;
    test_done;
  end
endmodule

// ### sim/serial_port_properties.sv
module serial_port_properties #(
  parameter int ADDR_W = 23,
  parameter int WORD_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_wdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_rw_exclusive: assert property (!(reg_wr && reg_rd))
    else $error("read and write together");
  chk_wr_spacing: assert property (reg_wr |=> !reg_wr [*8])
    else $error("write pulses too close");
  chk_rd_spacing: assert property (reg_rd |=> !reg_rd [*8])
    else $error("read pulses too close");
  chk_addr_hold: assert property ($changed(reg_addr) |-> reg_wr || reg_rd)
    else $error("address moved without request");
  chk_wdata_hold: assert property ($changed(reg_wdata) |-> reg_wr)
    else $error("write data moved without write");
  chk_oe_selected: assert property (!cs_n |-> serial_out_oe)
    else $error("output released while selected");
  chk_idle_mirror: assert property (cs_n && serial_out_oe |->
    serial_out == serial_in || serial_out)
    else $error("idle output neither mirror nor high");
  chk_reset_quiet: assert property ($fell(rst) |->
    !reg_wr && !reg_rd && reg_addr == '0)
    else $error("requests active out of reset");
endmodule

bind serial_host_register_port serial_port_properties #(
  .ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_props (.clk_sys(clk_sys), .rst(rst),
  .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata));
